/* core/vic_consts.svh */
// register indices, field positions, reset values and fixed figures of the vector controller
// assumes: included by bare name; byte address on the bus is four times an index
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

`define VIC_IDX_W 11
`define VIC_IDX_SHADOW 11'h376
`define VIC_IDX_LOCK 11'h459
`define VIC_IDX_CUR_L 11'h45a
`define VIC_IDX_CUR_M 11'h45b
`define VIC_IDX_CUR_U 11'h45c
`define VIC_IDX_BASE_L 11'h45d
`define VIC_IDX_BASE_M 11'h45e
`define VIC_IDX_BASE_U 11'h45f
`define VIC_IDX_IRQ_EN0 11'h4a8
`define VIC_IDX_IRQ_EN1 11'h4a9
`define VIC_IDX_CTRL 11'h4d6
`define VIC_IDX_NEST 11'h4d7
`define VIC_IDX_CFG 11'h4e0
`define VIC_IDX_UNLOCK 11'h4e1
`define VIC_IDX_STATUS 11'h4e2
`define VIC_IDX_MASK 11'h4e3

`define VIC_CTRL_EDGE_LSB 0
`define VIC_CTRL_PRIO_BIT 5
`define VIC_CTRL_RESET 8'h07
`define VIC_CTRL_WMASK 8'h27
`define VIC_NEST_LSB 6
`define VIC_LOCK_BIT 0
`define VIC_SHADOW_BIT 0
`define VIC_CFG_VEC_BIT 0
`define VIC_CFG_ONEWAY_BIT 1
`define VIC_UPPER_MASK 8'h1f

`define VIC_STAT_W 4
`define VIC_STAT_REFUSED 3

`define VIC_KEY_FIRST 8'h55
`define VIC_KEY_SECOND 8'haa
`define VIC_FIXED_VECTOR 21'h000008
`define VIC_RESP_OK 2'b00
`define VIC_RESP_SLVERR 2'b10

`endif

/* core/vic_pkg.sv */
// types shared by the vector controller register block and its nesting tracker
// assumes: compiled before every other design file
package vic_pkg;

	typedef enum logic [1:0] {
		VIC_NEST_MAIN,
		VIC_NEST_LOW,
		VIC_NEST_HIGH_FROM_MAIN,
		VIC_NEST_HIGH_OVER_LOW
	} vic_nest_t;

	typedef enum logic [1:0] {
		VIC_UNL_IDLE,
		VIC_UNL_KEY1,
		VIC_UNL_ARMED
	} vic_unlock_t;

	// one vector fetch by the core
	typedef struct packed {
		logic valid;
		logic low_prio;
		logic [7:0] number;
	} vic_fetch_t;

	// core handler entry and return events
	typedef struct packed {
		logic high_enter;
		logic low_enter;
		logic handler_return;
	} vic_core_evt_t;

endpackage : vic_pkg

/* core/vic_nest.sv */
// nesting-state tracker of the vector controller
// assumes: one-cycle core event pulses on CLK, at most one per cycle
module vic_nest (
	input wire logic clk,
	input wire logic reset,
	input wire vic_pkg::vic_core_evt_t evt,
	output logic [1:0] state_code
);
	vic_pkg::vic_nest_t state;
	vic_pkg::vic_nest_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			vic_pkg::VIC_NEST_MAIN: begin
				if (evt.high_enter) begin
					next_state = vic_pkg::VIC_NEST_HIGH_FROM_MAIN; // [R02]
				end else if (evt.low_enter) begin
					next_state = vic_pkg::VIC_NEST_LOW; // [R03]
				end
			end
			vic_pkg::VIC_NEST_LOW: begin
				if (evt.high_enter) begin
					next_state = vic_pkg::VIC_NEST_HIGH_OVER_LOW; // [R02]
				end else if (evt.handler_return) begin
					next_state = vic_pkg::VIC_NEST_MAIN; // [R03]
				end
			end
			vic_pkg::VIC_NEST_HIGH_FROM_MAIN: begin
				if (evt.handler_return) begin
					next_state = vic_pkg::VIC_NEST_MAIN;
				end
			end
			vic_pkg::VIC_NEST_HIGH_OVER_LOW: begin
				if (evt.handler_return) begin
					next_state = vic_pkg::VIC_NEST_LOW;
				end
			end
			default: begin
				next_state = vic_pkg::VIC_NEST_MAIN;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= vic_pkg::VIC_NEST_MAIN;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		case (state)
			vic_pkg::VIC_NEST_HIGH_OVER_LOW: state_code = 2'h3; // [R02]
			vic_pkg::VIC_NEST_HIGH_FROM_MAIN: state_code = 2'h2; // [R02]
			vic_pkg::VIC_NEST_LOW: state_code = 2'h1; // [R03]
			default: state_code = 2'h0; // [R03]
		endcase
	end

endmodule : vic_nest

/* core/vic_regs.sv */
// register block of a vectored interrupt controller behind an Avalon-MM slave
// assumes: pins and core events synchronous to CLK; 32-bit bus, byte data in lane 0
// What this block does
// [R01] Each external pin triggers on a rising edge at polarity bit 1, on a falling edge at 0.
// [R02] Nesting state reads 11 for high over a low handler and 10 for high entered from main.
// [R03] Nesting state reads 01 in a low handler entered from main and 00 in the main routine.
// [R04] The vector table base is 21 read/write bits: upper 5, middle 8, lower 8; reset zero.
// [R05] The current vector table address is 21 read-only bits in the same bytes, reset zero.
// [R06] While the base write lock is 1, base byte writes are ignored; at 0 they land.
// [R07] The lock bit changes only after the unlock sequence; any other attempt is ignored.
// [R08] With the one-way config bit at 1, a set lock cannot be cleared until reset.
// [R09] Shadow switch at 1 routes shadow access to the main copy, at 0 to the low handler copy.
// [R10] Each enable bit passes its source request at 1 and blocks it at 0; all reset to 0.
// [R11] Enable register 0 holds pin change down to software interrupt enables, bit 7 to 0.
// [R12] Enable register 1 holds pulse-width capture down to external pin a enables, bit 7 to 0.
// [R13] A valid edge of the chosen polarity sets the pin's event flag, which software clears.
// [R14] With vectoring and priority both off, every interrupt goes to fixed address 0008h.
// [R15] With vectoring on, each vector fetch loads the current address with base plus twice the vector number.
// [R16] Writes to the current address bytes and the nesting field leave them unchanged.
`include "vic_consts.svh"

module vic_regs #(
	parameter int unsigned N_PINS = 3,
	parameter logic VEC_EN_RESET = 1'b1,
	parameter logic ONE_WAY_RESET = 1'b0,
	parameter logic [20:0] LOW_COMPAT_ADDR = 21'h000018
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [12:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic [1:0] AVS_RESPONSE,
	output logic AVS_WAITREQUEST,
	input wire logic [N_PINS-1:0] EXT_IRQ_PIN,
	input wire logic [15:0] PERIPH_REQ,
	output logic [15:0] PERIPH_IRQ,
	input wire vic_pkg::vic_fetch_t CORE_FETCH,
	input wire vic_pkg::vic_core_evt_t CORE_EVT,
	output logic [20:0] VECTOR_ADDR,
	output logic SHADOW_MAIN_SEL,
	output logic IRQ
);
	// bus handshake
	logic ack;
	logic [`VIC_IDX_W-1:0] idx;
	logic aligned;
	logic wr_go;
	logic [7:0] wbyte;
	logic hit;
	logic [7:0] rbyte;

	// register state
	logic [7:0] ctrl;
	logic [20:0] base;
	logic [20:0] cur_addr;
	logic base_write_lock;
	logic shadow_bank_switch;
	logic vectoring_enable;
	logic one_way_lock_config;
	logic [7:0] peripheral_irq_enable_0;
	logic [7:0] peripheral_irq_enable_1;
	logic [`VIC_STAT_W-1:0] status;
	logic [`VIC_STAT_W-1:0] mask;
	logic [1:0] nest_code;
	vic_pkg::vic_unlock_t unlock;
	vic_pkg::vic_unlock_t next_unlock;

	// edge detection, lock and base refusal, priority enable
	logic [N_PINS-1:0] pin_prev;
	logic primed;
	logic [N_PINS-1:0] pin_event;
	logic [`VIC_STAT_W-1:0] stat_set;
	logic lock_attempt;
	logic lock_refused;
	logic base_refused;
	logic priority_levels_enable;

	assign idx = AVS_ADDRESS[12:2];
	assign aligned = (AVS_ADDRESS[1:0] == 2'h0);
	assign wbyte = AVS_WRITEDATA[7:0];
	// a write lands on the edge where waitrequest is seen low
	assign wr_go = AVS_WRITE && ack && AVS_BYTEENABLE[0];
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign priority_levels_enable = ctrl[`VIC_CTRL_PRIO_BIT];

	// one wait state: ack is high only in the cycle after a request is seen
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ack <= 1'b0;
		end else begin
			ack <= (AVS_READ || AVS_WRITE) && !ack;
		end
	end

	// address decode and read mux
	always_comb begin
		hit = aligned;
		rbyte = 8'h00;
		case (idx)
			`VIC_IDX_SHADOW: rbyte = {7'h00, shadow_bank_switch};
			`VIC_IDX_LOCK: rbyte = {7'h00, base_write_lock};
			`VIC_IDX_CUR_L: rbyte = cur_addr[7:0]; // [R05]
			`VIC_IDX_CUR_M: rbyte = cur_addr[15:8]; // [R05]
			`VIC_IDX_CUR_U: rbyte = {3'h0, cur_addr[20:16]}; // [R05]
			`VIC_IDX_BASE_L: rbyte = base[7:0]; // [R04]
			`VIC_IDX_BASE_M: rbyte = base[15:8]; // [R04]
			`VIC_IDX_BASE_U: rbyte = {3'h0, base[20:16]}; // [R04]
			`VIC_IDX_IRQ_EN0: rbyte = peripheral_irq_enable_0;
			`VIC_IDX_IRQ_EN1: rbyte = peripheral_irq_enable_1;
			`VIC_IDX_CTRL: rbyte = ctrl;
			`VIC_IDX_NEST: rbyte = {nest_code, 6'h00};
			`VIC_IDX_CFG: rbyte = {6'h00, one_way_lock_config, vectoring_enable};
			`VIC_IDX_UNLOCK: rbyte = 8'h00;
			`VIC_IDX_STATUS: rbyte = {{(8-`VIC_STAT_W){1'b0}}, status};
			`VIC_IDX_MASK: rbyte = {{(8-`VIC_STAT_W){1'b0}}, mask};
			default: hit = 1'b0;
		endcase
	end

	// read data and response captured in the waited cycle, standing at the accepting edge
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			AVS_READDATA <= 32'h00000000;
			AVS_RESPONSE <= `VIC_RESP_OK;
		end else if ((AVS_READ || AVS_WRITE) && !ack) begin
			AVS_READDATA <= (AVS_READ && hit) ? {24'h000000, rbyte} : 32'h00000000;
			AVS_RESPONSE <= hit ? `VIC_RESP_OK : `VIC_RESP_SLVERR;
		end
	end

	// control: edge polarity and priority enable
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl <= `VIC_CTRL_RESET;
		end else if (wr_go && aligned && idx == `VIC_IDX_CTRL) begin
			ctrl <= wbyte & `VIC_CTRL_WMASK;
		end
	end

	// vector table base, gated by the lock
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			base <= 21'h000000; // [R04]
		end else if (wr_go && aligned && !base_write_lock) begin // [R06]
			case (idx)
				`VIC_IDX_BASE_L: base[7:0] <= wbyte; // [R04]
				`VIC_IDX_BASE_M: base[15:8] <= wbyte; // [R04]
				`VIC_IDX_BASE_U: base[20:16] <= 5'(wbyte & `VIC_UPPER_MASK); // [R04]
				default: base <= base;
			endcase
		end
	end

	// a refused base write is reported in status bit 3
	assign base_refused = wr_go && aligned && base_write_lock
		&& (idx == `VIC_IDX_BASE_L || idx == `VIC_IDX_BASE_M || idx == `VIC_IDX_BASE_U); // [R06]

	// current address only moves on a fetch; bus writes never reach it
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cur_addr <= 21'h000000; // [R05]
		end else if (CORE_FETCH.valid) begin
			if (vectoring_enable) begin
				cur_addr <= base + {12'h000, CORE_FETCH.number, 1'b0}; // [R15]
			end else if (priority_levels_enable && CORE_FETCH.low_prio) begin
				cur_addr <= LOW_COMPAT_ADDR;
			end else begin
				cur_addr <= `VIC_FIXED_VECTOR; // [R14]
			end
		end
	end // [R16]

	assign VECTOR_ADDR = cur_addr;

	// unlock sequence: first key, second key, then one lock write
	assign lock_attempt = wr_go && aligned && idx == `VIC_IDX_LOCK;

	always_comb begin
		next_unlock = unlock;
		case (unlock)
			vic_pkg::VIC_UNL_IDLE: begin
				if (wr_go && aligned && idx == `VIC_IDX_UNLOCK && wbyte == `VIC_KEY_FIRST) begin
					next_unlock = vic_pkg::VIC_UNL_KEY1;
				end
			end
			vic_pkg::VIC_UNL_KEY1: begin
				if (wr_go) begin
					if (aligned && idx == `VIC_IDX_UNLOCK && wbyte == `VIC_KEY_SECOND) begin
						next_unlock = vic_pkg::VIC_UNL_ARMED;
					end else begin
						next_unlock = vic_pkg::VIC_UNL_IDLE;
					end
				end
			end
			vic_pkg::VIC_UNL_ARMED: begin
				if (wr_go) begin
					next_unlock = vic_pkg::VIC_UNL_IDLE;
				end
			end
			default: begin
				next_unlock = vic_pkg::VIC_UNL_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			unlock <= vic_pkg::VIC_UNL_IDLE;
		end else begin
			unlock <= next_unlock;
		end
	end

	// lock refused without sequence, or a clear blocked by one-way config
	assign lock_refused = lock_attempt && (unlock != vic_pkg::VIC_UNL_ARMED
		|| (one_way_lock_config && base_write_lock && !wbyte[`VIC_LOCK_BIT]));

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			base_write_lock <= 1'b0;
		end else if (lock_attempt && !lock_refused) begin // [R07]
			base_write_lock <= wbyte[`VIC_LOCK_BIT]; // [R08]
		end
	end

	// configuration word; the one-way bit cannot be dropped once set
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			vectoring_enable <= VEC_EN_RESET;
			one_way_lock_config <= ONE_WAY_RESET;
		end else if (wr_go && aligned && idx == `VIC_IDX_CFG) begin
			vectoring_enable <= wbyte[`VIC_CFG_VEC_BIT];
			one_way_lock_config <= one_way_lock_config | wbyte[`VIC_CFG_ONEWAY_BIT]; // [R08]
		end
	end

	// shadow bank routing
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			shadow_bank_switch <= 1'b0;
		end else if (wr_go && aligned && idx == `VIC_IDX_SHADOW) begin
			shadow_bank_switch <= wbyte[`VIC_SHADOW_BIT];
		end
	end

	// the shadow copies sit outside this block; only the routing leaves it
	assign SHADOW_MAIN_SEL = shadow_bank_switch; // [R09]

	// peripheral enable register 0
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			peripheral_irq_enable_0 <= 8'h00; // [R10]
		end else if (wr_go && aligned && idx == `VIC_IDX_IRQ_EN0) begin
			peripheral_irq_enable_0 <= wbyte; // [R11]
		end
	end

	// peripheral enable register 1
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			peripheral_irq_enable_1 <= 8'h00; // [R10]
		end else if (wr_go && aligned && idx == `VIC_IDX_IRQ_EN1) begin
			peripheral_irq_enable_1 <= wbyte; // [R12]
		end
	end

	// enable 0: pin change, checksum, logic cell 1, nvm, clock switch, osc fail, voltage, software
	// enable 1: pulse width, period, meas timer, comparator 1, tuning, converter, zero cross, pin a
	always_comb begin
		PERIPH_IRQ[7:0] = PERIPH_REQ[7:0] & peripheral_irq_enable_0; // [R10] [R11]
		PERIPH_IRQ[15:9] = PERIPH_REQ[15:9] & peripheral_irq_enable_1[7:1]; // [R10] [R12]
		PERIPH_IRQ[8] = (PERIPH_REQ[8] | status[0]) & peripheral_irq_enable_1[0]; // [R12]
	end

	// previous pin levels for edge detection
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pin_prev <= '0;
		end else begin
			pin_prev <= EXT_IRQ_PIN;
		end
	end

	// edge detection armed one cycle after reset release
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			primed <= 1'b0;
		end else begin
			primed <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_PINS; g++) begin : g_pin
			assign pin_event[g] = primed && (ctrl[`VIC_CTRL_EDGE_LSB + g]
				? (EXT_IRQ_PIN[g] && !pin_prev[g])
				: (!EXT_IRQ_PIN[g] && pin_prev[g])); // [R01]
		end
	endgenerate

	always_comb begin
		stat_set = '0;
		stat_set[N_PINS-1:0] = pin_event; // [R13]
		stat_set[`VIC_STAT_REFUSED] = lock_refused || base_refused;
	end

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			status <= '0;
		end else if (wr_go && aligned && idx == `VIC_IDX_STATUS) begin
			status <= (status & ~wbyte[`VIC_STAT_W-1:0]) | stat_set; // [R13]
		end else begin
			status <= status | stat_set; // [R13]
		end
	end

	// interrupt mask, same layout as status
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mask <= '0;
		end else if (wr_go && aligned && idx == `VIC_IDX_MASK) begin
			mask <= wbyte[`VIC_STAT_W-1:0];
		end
	end

	// level output, high while any unmasked flag stands
	assign IRQ = |(status & mask);

	// nesting field is driven only by core events
	vic_nest u_nest (
		.clk(CLK),
		.reset(RESET),
		.evt(CORE_EVT),
		.state_code(nest_code)
	); // [R02] [R03] [R16]

endmodule : vic_regs

/* tb/vic_regs_props.sv */
// port assertions of the vector controller register block
// assumes: bound to vic_regs; one clock, reset active high
module vic_regs_props #(
	parameter int unsigned N_PINS = 3
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [12:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic [1:0] AVS_RESPONSE,
	input wire logic AVS_WAITREQUEST,
	input wire logic [N_PINS-1:0] EXT_IRQ_PIN,
	input wire logic [15:0] PERIPH_REQ,
	input wire logic [15:0] PERIPH_IRQ,
	input wire vic_pkg::vic_fetch_t CORE_FETCH,
	input wire vic_pkg::vic_core_evt_t CORE_EVT,
	input wire logic [20:0] VECTOR_ADDR,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	logic [1:0] nest_q;
	logic done;
	assign done = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
	// nesting code expected from the core events
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			nest_q <= 2'h0;
		end else if (CORE_EVT.high_enter) begin
			nest_q <= {1'h1, nest_q[0]};
		end else if (CORE_EVT.low_enter) begin
			nest_q <= 2'h1;
		end else if (CORE_EVT.handler_return) begin
			nest_q <= {1'h0, nest_q[1] & nest_q[0]};
		end
	end
	sequence s_one_wait;
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence
	chk_one_wait: assert property ($rose(AVS_READ | AVS_WRITE) |-> s_one_wait)
		else $error("bus wait not one cycle");
	chk_misalign_err: assert property (done && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_RESPONSE == 2'h2)
		else $error("misaligned access not refused");
	chk_byte_lane: assert property (done && AVS_READ |-> AVS_READDATA[31:8] == 24'h0)
		else $error("read data above byte lane");
	chk_cur_read: assert property (done && AVS_READ && AVS_ADDRESS == 13'h1168 |->
		AVS_READDATA[7:0] == VECTOR_ADDR[7:0]) else $error("current address read wrong");
	chk_nest_read: assert property (done && AVS_READ && AVS_ADDRESS == 13'h135c |->
		AVS_READDATA[7:6] == nest_q) else $error("nesting code wrong");
	chk_enable_gate: assert property ((PERIPH_IRQ & ~PERIPH_REQ & 16'hfeff) == 16'h0)
		else $error("request passed without source");
	chk_addr_hold: assert property (!CORE_FETCH.valid |=> $stable(VECTOR_ADDR))
		else $error("vector address moved without fetch");
	chk_irq_steady: assert property ($stable(EXT_IRQ_PIN) && !AVS_WRITE |=> $stable(IRQ))
		else $error("interrupt moved without cause");
endmodule : vic_regs_props

bind vic_regs vic_regs_props #(.N_PINS(N_PINS)) u_props (.CLK(CLK), .RESET(RESET),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.EXT_IRQ_PIN(EXT_IRQ_PIN), .PERIPH_REQ(PERIPH_REQ), .PERIPH_IRQ(PERIPH_IRQ),
	.CORE_FETCH(CORE_FETCH), .CORE_EVT(CORE_EVT), .VECTOR_ADDR(VECTOR_ADDR), .IRQ(IRQ));

/* tb/vic_core_model.sv */
// processor core side: vector fetch and handler entry or return pulses
// assumes: tasks are entered just after a rising edge of clk
module vic_core_model (
	input wire logic clk,
	output vic_pkg::vic_fetch_t fetch,
	output vic_pkg::vic_core_evt_t evt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fetch = '0;
		evt = '0;
	end
	task automatic do_fetch(input logic [7:0] num, input logic low);
		fetch <= '{valid: 1'h1, low_prio: low, number: num};
		@(posedge clk);
		fetch <= '0;
		@(posedge clk);
	endtask : do_fetch
	// one pulse at a time, then a quiet cycle
	task automatic do_evt(input vic_pkg::vic_core_evt_t e);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask : do_evt
endmodule : vic_core_model

/* tb/tb_top.sv */
// self-checking bench of the vector controller register block
// assumes: design package, design modules and the core model compiled first
`include "vic_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK;
	logic RESET;
	logic [12:0] AVS_ADDRESS;
	logic AVS_READ;
	logic AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [31:0] AVS_READDATA;
	logic [1:0] AVS_RESPONSE;
	logic AVS_WAITREQUEST;
	logic [2:0] EXT_IRQ_PIN;
	logic [15:0] PERIPH_REQ;
	logic [15:0] PERIPH_IRQ;
	vic_pkg::vic_fetch_t CORE_FETCH;
	vic_pkg::vic_core_evt_t CORE_EVT;
	logic [20:0] VECTOR_ADDR;
	logic SHADOW_MAIN_SEL;
	logic IRQ;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] rdata;
	logic [1:0] rresp;

	vic_regs uut (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'h1),
		.AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_IRQ_PIN(EXT_IRQ_PIN), .PERIPH_REQ(PERIPH_REQ),
		.PERIPH_IRQ(PERIPH_IRQ), .CORE_FETCH(CORE_FETCH), .CORE_EVT(CORE_EVT),
		.VECTOR_ADDR(VECTOR_ADDR), .SHADOW_MAIN_SEL(SHADOW_MAIN_SEL), .IRQ(IRQ));
	vic_core_model core (.clk(CLK), .fetch(CORE_FETCH), .evt(CORE_EVT));

	initial begin
		CLK = 1'h0;
		forever #4 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// request held until waitrequest is sampled low at a rising edge, then released
	task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= ~w;
		AVS_WRITEDATA <= {24'h0, d};
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'h0) @(posedge CLK);
		rdata = AVS_READDATA[7:0];
		rresp = AVS_RESPONSE;
		AVS_WRITE <= 1'h0;
		AVS_READ <= 1'h0;
		@(posedge CLK);
	endtask : acc
	task automatic wr(input logic [10:0] i, input logic [7:0] d);
		acc(1'h1, {i, 2'h0}, d);
	endtask : wr
	task automatic rc(input string nm, input logic [10:0] i, input logic [7:0] exp);
		acc(1'h0, {i, 2'h0}, 8'h0);
		check(nm, {24'h0, rdata}, {24'h0, exp});
	endtask : rc
	task automatic unlock();
		wr(`VIC_IDX_UNLOCK, `VIC_KEY_FIRST);
		wr(`VIC_IDX_UNLOCK, `VIC_KEY_SECOND);
	endtask : unlock
	task automatic t_reset();
		logic [10:0] ix [10];
		ix = '{`VIC_IDX_BASE_L, `VIC_IDX_BASE_M, `VIC_IDX_BASE_U, `VIC_IDX_CUR_L, `VIC_IDX_CUR_M,
			`VIC_IDX_CUR_U, `VIC_IDX_IRQ_EN0, `VIC_IDX_IRQ_EN1, `VIC_IDX_NEST, `VIC_IDX_CTRL};
		for (int k = 0; k < 10; k++) begin
			rc("reset value", ix[k], k == 9 ? `VIC_CTRL_RESET : 8'h00);
		end
	endtask : t_reset
	task automatic t_base();
		wr(`VIC_IDX_MASK, 8'h0f);
		for (int k = 0; k < 3; k++) begin
			wr(`VIC_IDX_BASE_L + 11'(k), 8'hff);
			rc("base", `VIC_IDX_BASE_L + 11'(k), k == 2 ? `VIC_UPPER_MASK : 8'hff);
		end
		wr(`VIC_IDX_LOCK, 8'h01);
		rc("lock no key", `VIC_IDX_LOCK, 8'h00);
		check("refused irq", IRQ, 1'h1);
		wr(`VIC_IDX_STATUS, 8'h08);
		unlock();
		wr(`VIC_IDX_BASE_L, 8'hff);
		wr(`VIC_IDX_LOCK, 8'h01);
		rc("lock disarmed", `VIC_IDX_LOCK, 8'h00);
		unlock();
		wr(`VIC_IDX_LOCK, 8'h01);
		rc("lock set", `VIC_IDX_LOCK, 8'h01);
		wr(`VIC_IDX_BASE_M, 8'h12);
		rc("locked base", `VIC_IDX_BASE_M, 8'hff);
		unlock();
		wr(`VIC_IDX_LOCK, 8'h00);
		wr(`VIC_IDX_BASE_M, 8'h12);
		rc("open base", `VIC_IDX_BASE_M, 8'h12);
	endtask : t_base
	task automatic t_fetch();
		logic [20:0] exp;
		exp = 21'h1f12ff + 21'h2 * 21'h81;
		core.do_fetch(8'h81, 1'h0);
		check("vector", VECTOR_ADDR, exp);
		rc("cur low", `VIC_IDX_CUR_L, exp[7:0]);
		rc("cur up", `VIC_IDX_CUR_U, {3'h0, exp[20:16]});
		wr(`VIC_IDX_CUR_M, 8'h00);
		rc("cur mid", `VIC_IDX_CUR_M, exp[15:8]);
		wr(`VIC_IDX_CFG, 8'h00);
		core.do_fetch(8'h81, 1'h0);
		check("fixed vector", VECTOR_ADDR, `VIC_FIXED_VECTOR);
		wr(`VIC_IDX_CTRL, 8'h27);
		core.do_fetch(8'h81, 1'h1);
		check("low compat", VECTOR_ADDR, 32'h00000018);
		wr(`VIC_IDX_CTRL, `VIC_CTRL_RESET);
		wr(`VIC_IDX_CFG, 8'h01);
	endtask : t_fetch
	task automatic t_nest();
		vic_pkg::vic_core_evt_t ev [6];
		logic [1:0] ex [6];
		ev = '{3'h4, 3'h1, 3'h2, 3'h4, 3'h1, 3'h1};
		ex = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h0};
		for (int k = 0; k < 6; k++) begin
			core.do_evt(ev[k]);
			rc("nesting", `VIC_IDX_NEST, {ex[k], 6'h0});
		end
		wr(`VIC_IDX_NEST, 8'hc0);
		rc("nesting ro", `VIC_IDX_NEST, 8'h00);
	endtask : t_nest
	task automatic edge_try(input int p, input logic lvl, input logic hit);
		EXT_IRQ_PIN[p] <= lvl;
		repeat (3) @(posedge CLK);
		check("pin irq", IRQ, hit);
		rc("pin flag", `VIC_IDX_STATUS, hit ? 8'h01 << p : 8'h00);
		wr(`VIC_IDX_STATUS, 8'h07);
		check("flag cleared", IRQ, 1'h0);
	endtask : edge_try
	task automatic t_pins();
		wr(`VIC_IDX_STATUS, 8'h0f);
		wr(`VIC_IDX_MASK, 8'h07);
		for (int p = 0; p < 3; p++) begin
			edge_try(p, 1'h1, 1'h1);
			wr(`VIC_IDX_CTRL, 8'h00);
			edge_try(p, 1'h0, 1'h1);
			edge_try(p, 1'h1, 1'h0);
			wr(`VIC_IDX_CTRL, 8'h07);
			edge_try(p, 1'h0, 1'h0);
		end
	endtask : t_pins
	task automatic t_enables();
		PERIPH_REQ <= 16'hffff;
		for (int b = 0; b < 16; b++) begin
			wr(b < 8 ? `VIC_IDX_IRQ_EN0 : `VIC_IDX_IRQ_EN1, 8'h01 << (b % 8));
			wr(b < 8 ? `VIC_IDX_IRQ_EN1 : `VIC_IDX_IRQ_EN0, 8'h00);
			check("enable gate", PERIPH_IRQ, 16'h1 << b);
		end
		rc("enable 1", `VIC_IDX_IRQ_EN1, 8'h80);
		PERIPH_REQ <= 16'h0;
		@(posedge CLK);
		check("no request", PERIPH_IRQ, 16'h0);
	endtask : t_enables
	task automatic t_misc();
		wr(`VIC_IDX_SHADOW, 8'h01);
		check("shadow main", SHADOW_MAIN_SEL, 1'h1);
		wr(`VIC_IDX_SHADOW, 8'h00);
		check("shadow low", SHADOW_MAIN_SEL, 1'h0);
		wr(`VIC_IDX_CFG, 8'h03);
		unlock();
		wr(`VIC_IDX_LOCK, 8'h01);
		unlock();
		wr(`VIC_IDX_LOCK, 8'h00);
		rc("one way", `VIC_IDX_LOCK, 8'h01);
		acc(1'h0, 13'h1169, 8'h00);
		check("misaligned", rresp, `VIC_RESP_SLVERR);
	endtask : t_misc
	// mid-run reset releases the one-way lock
	task automatic t_rearm();
		RESET <= 1'h1;
		repeat (2) @(posedge CLK);
		RESET <= 1'h0;
		@(posedge CLK);
		rc("lock after reset", `VIC_IDX_LOCK, 8'h00);
		rc("base after reset", `VIC_IDX_BASE_M, 8'h00);
		unlock();
		wr(`VIC_IDX_LOCK, 8'h01);
		unlock();
		wr(`VIC_IDX_LOCK, 8'h00);
		rc("lock clear again", `VIC_IDX_LOCK, 8'h00);
	endtask : t_rearm

	initial begin
		RESET = 1'h1;
		AVS_ADDRESS = 13'h0;
		AVS_READ = 1'h0;
		AVS_WRITE = 1'h0;
		AVS_WRITEDATA = 32'h0;
		EXT_IRQ_PIN = 3'h0;
		PERIPH_REQ = 16'h0;
		repeat (2) @(posedge CLK);
		RESET <= 1'h0;
		repeat (2) @(posedge CLK);
		t_reset();
		t_base();
		t_fetch();
		t_nest();
		t_pins();
		t_enables();
		t_misc();
		t_rearm();
		test_done();
	end
endmodule : tb_top
